// File: core/fpg_pkg.sv
/*
 * fpg_pkg: shared constants and types of the flash program guard host
 * controller: device register addresses, control bit positions, timing
 * counts, user command and device bus carriers.
 * Assumes a 250 MHz controller clock (mclk) and a byte-wide register
 * path to the device.
 */
package fpg_pkg;

  // ------------
  // device register addresses (byte registers, byte access only)
  // ------------
  localparam logic [19:0] FPG_ADDR_FLASH_CONTROL_ONE = 20'hee030;
  localparam logic [19:0] FPG_ADDR_FLASH_CONTROL_TWO = 20'hee031;
  localparam logic [19:0] FPG_ADDR_ERASE_BLOCK_SELECT_ONE = 20'hee032;
  localparam logic [19:0] FPG_ADDR_ERASE_BLOCK_SELECT_TWO = 20'hee033;
  localparam logic [19:0] FPG_ADDR_RAM_OVERLAY_CONTROL = 20'hee077;
  localparam logic [19:0] FPG_ADDR_WATCHDOG = 20'hfff8c;
  localparam logic [19:0] FPG_FLASH_LAST = 20'h3ffff;

  // ------------
  // flash_control_one bit positions and reset value
  // ------------
  localparam int FPG_BIT_SOFTWARE_WRITE_PERMIT = 6;
  localparam int FPG_BIT_ERASE_SETUP = 5;
  localparam int FPG_BIT_PROGRAM_SETUP = 4;
  localparam int FPG_BIT_ERASE_VERIFY = 3;
  localparam int FPG_BIT_PROGRAM_VERIFY = 2;
  localparam int FPG_BIT_ERASE = 1;
  localparam int FPG_BIT_PROGRAM = 0;
  localparam logic [7:0] FPG_FC1_RESET = 8'h00;

  // ------------
  // programming unit bookkeeping: 128-byte units over the flash array
  // ------------
  localparam int FPG_UNIT_LSB = 7;
  localparam int FPG_UNIT_BITS = 11;
  localparam int FPG_UNITS = 2048;

  // ------------
  // timing: figures in their own unit, counts derived at 4 ns per cycle
  // ------------
  localparam int FPG_CLK_NS = 4;
  localparam int FPG_MODE_SETUP_NS = 200;
  localparam int FPG_DEV_CLK_NS = 40;
  localparam int FPG_RESET_MIN_DEV_CYCLES = 20;
  localparam int FPG_SWE_WAIT_NS = 1000;
  localparam int FPG_READ_WAIT_US = 100;
  localparam int FPG_ACCESS_CYCLES = 6;
  localparam int FPG_MODE_SETUP_CYCLES =
    (FPG_MODE_SETUP_NS + FPG_CLK_NS - 1) / FPG_CLK_NS;
  localparam int FPG_RESET_CYCLES =
    (FPG_RESET_MIN_DEV_CYCLES * FPG_DEV_CLK_NS + FPG_CLK_NS - 1)
    / FPG_CLK_NS;
  localparam int FPG_RESET_HOLD_CYCLES =
    (FPG_RESET_CYCLES > FPG_MODE_SETUP_CYCLES) ?
    FPG_RESET_CYCLES : FPG_MODE_SETUP_CYCLES;
  localparam int FPG_SWE_WAIT_CYCLES =
    (FPG_SWE_WAIT_NS + FPG_CLK_NS - 1) / FPG_CLK_NS;
  localparam int FPG_READ_WAIT_CYCLES =
    (FPG_READ_WAIT_US * 1000 + FPG_CLK_NS - 1) / FPG_CLK_NS;

  // ------------
  // user commands and carriers
  // ------------
  typedef enum logic [3:0] {
    FPG_OP_MODE_RESET = 4'h0,
    FPG_OP_FWE_ON = 4'h1,
    FPG_OP_FWE_OFF = 4'h2,
    FPG_OP_WDT_ARM = 4'h3,
    FPG_OP_REG_WR = 4'h4,
    FPG_OP_REG_RD = 4'h5,
    FPG_OP_FLASH_RD = 4'h6,
    FPG_OP_FLASH_WR = 4'h7,
    FPG_OP_MAP_CLEAR = 4'h8
  } fpg_op_t;

  typedef struct packed {
    fpg_op_t op;
    logic [19:0] addr;
    logic [7:0] data;
  } fpg_cmd_t;

  typedef struct packed {
    logic ok;
    logic [7:0] data;
  } fpg_rsp_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } fpg_bus_t;

endpackage : fpg_pkg

// File: core/fpg_wait_timer.sv
/*
 * fpg_wait_timer: down counter that emits a one-cycle done pulse a
 * loaded number of cycles after its load strobe.
 * Assumes load_val is at least one and that the caller ignores done
 * while it reloads.
 */
`timescale 1ns/1ns
module fpg_wait_timer
  import fpg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic done
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic next_done;

  // ------------
  // count down, pulse done when the last cycle passes
  // ------------
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (load) begin
      next_count = load_val;
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
      next_done = (count == 16'h0001);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

endmodule : fpg_wait_timer

// File: core/fpg_host.sv
/*
 * fpg_host: host side controller that drives a flash microcontroller
 * through its reset, write-permit and mode pins and a byte register
 * path, and guards programming, erasing and interrupt requests.
 * Assumes user commands come from logic on mclk and device read data
 * arrives asynchronously on dev_rdata.
 */
`timescale 1ns/1ns

// Notes on behaviour
// R01: device blocks nmi while program or erase bit set, or boot runs.
// R02: device also blocks nmi in error protection and emulation with p/e.
// R03: boot-mode nmi block ends at branch to ram boot program.
// R04: flash reads during program or erase return undetermined data.
// R05: while write permit pin high, host suppresses interrupts and bus release.
// R06: each 128-byte unit programmed once; erase before reprogramming. Host refuses only offset-0 rewrites, until a map clear.
// R07: device offers prom-mode verify, program and total erase.
// R08: device has no identification mode; device type chosen by hand.
// R09: boot entry: permit pin and mode pins set in reset, setup met.
// R10: reset during operation held low at least 20 system clocks.
// R11: device accepts permit pin changes anytime in user program mode.
// R12: drop permit pin only with all control bits of register one clear.
// R13: arm watchdog before program or erase; keep it while pin high.
// R14: no ordinary flash access while program or erase bit set.
// R15: clear software write permit before reading flash; verify only else.
// R16: device keeps overlay ram accessible whatever the permit bit.
// R17: wait after clearing software write permit before normal access.
// R18: wait 100 us after leaving program, erase or verify before reads.
// R19: control, erase block and overlay registers accessed bytewise only.
// R20: permit pin high only for program, erase or emulation.
// R21: device flags error, aborts program/erase on malfunction.
// R22: device clears program and erase bits on reset, standby, pin low.
// R23: device drops nmi edges that arrive while blocked.
module fpg_host
  import fpg_pkg::*;
#(
  parameter int READ_WAIT_CYCLES = FPG_READ_WAIT_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire fpg_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output fpg_rsp_t rsp,
  input wire logic user_nmi,
  input wire logic user_bus_req,
  output logic dev_res_n,
  output logic dev_write_permit,
  output logic [2:0] dev_mode_select,
  output logic dev_nmi,
  output logic dev_bus_req,
  output fpg_bus_t dev_bus,
  input wire logic [7:0] dev_rdata
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RESET = 4'b0010,
    ST_ACCESS = 4'b0100,
    ST_SETTLE = 4'b1000
  } fpg_state_t;

  // ------------
  // decoders used in several places
  // ------------
  function automatic logic fpg_pe_set(input logic [7:0] v);
    fpg_pe_set = v[FPG_BIT_PROGRAM] | v[FPG_BIT_ERASE];
  endfunction : fpg_pe_set

  function automatic logic fpg_mode_set(input logic [7:0] v);
    fpg_mode_set = fpg_pe_set(v) | v[FPG_BIT_PROGRAM_VERIFY]
      | v[FPG_BIT_ERASE_VERIFY];
  endfunction : fpg_mode_set

  function automatic logic fpg_any_ctrl(input logic [7:0] v);
    fpg_any_ctrl = fpg_mode_set(v) | v[FPG_BIT_PROGRAM_SETUP]
      | v[FPG_BIT_ERASE_SETUP] | v[FPG_BIT_SOFTWARE_WRITE_PERMIT];
  endfunction : fpg_any_ctrl

  // ------------
  // reset release and read data synchronisers
  // ------------
  logic rst_q1;
  logic rst_sync_n;
  logic [7:0] rdata_q1;
  logic [7:0] rdata_q2;

  // reset is released through two flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  // device read data comes from another domain
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q1 <= 8'h00;
      rdata_q2 <= 8'h00;
    end else begin
      rdata_q1 <= dev_rdata;
      rdata_q2 <= rdata_q1;
    end
  end

  // ------------
  // timer shared by reset hold, access and settle waits
  // ------------
  logic tmr_load;
  logic [15:0] tmr_val;
  logic tmr_done;

  fpg_wait_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ------------
  // controller state
  // ------------
  fpg_state_t state;
  fpg_state_t next_state;
  logic [7:0] fc1;
  logic [7:0] next_fc1;
  logic wdt_armed;
  logic next_wdt_armed;
  logic [FPG_UNITS-1:0] prog_map;
  logic [FPG_UNITS-1:0] next_prog_map;
  logic [15:0] settle_val;
  logic [15:0] next_settle_val;
  logic next_cmd_ready;
  logic next_rsp_valid;
  fpg_rsp_t next_rsp;
  logic next_res_n;
  logic next_permit;
  logic [2:0] next_mode;
  fpg_bus_t next_bus;
  logic [FPG_UNIT_BITS-1:0] unit;
  logic in_flash;
  logic take;

  assign unit = cmd.addr[FPG_UNIT_LSB +: FPG_UNIT_BITS];
  assign in_flash = (cmd.addr <= FPG_FLASH_LAST);
  assign take = cmd_valid & cmd_ready;

  // next values of the command sequencer
  always_comb begin
    next_state = state;
    next_fc1 = fc1;
    next_wdt_armed = wdt_armed;
    next_prog_map = prog_map;
    next_settle_val = settle_val;
    next_cmd_ready = cmd_ready;
    next_rsp_valid = 1'b0;
    next_rsp = rsp;
    next_res_n = dev_res_n;
    next_permit = dev_write_permit;
    next_mode = dev_mode_select;
    next_bus = dev_bus;
    tmr_load = 1'b0;
    tmr_val = 16'(FPG_ACCESS_CYCLES);
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_rsp = '{ok: 1'b1, data: 8'h00};
          next_settle_val = 16'h0000;
          case (cmd.op)
            FPG_OP_MODE_RESET: begin
              // pins change only while reset is low, hold covers setup
              next_res_n = 1'b0; // see R09
              next_mode = cmd.data[2:0]; // see R09
              next_permit = cmd.data[3] & wdt_armed; // see R13
              next_fc1 = FPG_FC1_RESET;
              next_wdt_armed = 1'b0;
              tmr_load = 1'b1;
              tmr_val = 16'(FPG_RESET_HOLD_CYCLES); // see R10
              next_cmd_ready = 1'b0;
              next_state = ST_RESET;
            end
            FPG_OP_FWE_ON: begin
              // raised only on request for program, erase or emulation
              next_rsp.ok = wdt_armed; // see R13
              next_permit = dev_write_permit | wdt_armed; // see R20
              next_rsp_valid = 1'b1;
            end
            FPG_OP_FWE_OFF: begin
              next_rsp.ok = !fpg_any_ctrl(fc1); // see R12
              next_permit = dev_write_permit & fpg_any_ctrl(fc1);
              next_rsp_valid = 1'b1;
            end
            FPG_OP_WDT_ARM: begin
              next_wdt_armed = 1'b1;
              next_bus = '{addr: FPG_ADDR_WATCHDOG, wdata: cmd.data,
                           we: 1'b1, re: 1'b0};
              tmr_load = 1'b1;
              next_cmd_ready = 1'b0;
              next_state = ST_ACCESS;
            end
            FPG_OP_REG_WR: begin
              if (fpg_pe_set(cmd.data) && !wdt_armed
                  && cmd.addr == FPG_ADDR_FLASH_CONTROL_ONE) begin
                next_rsp.ok = 1'b0; // see R13
                next_rsp_valid = 1'b1;
              end else begin
                if (cmd.addr == FPG_ADDR_FLASH_CONTROL_ONE) begin
                  next_fc1 = dev_write_permit ? cmd.data : FPG_FC1_RESET;
                  if (fpg_mode_set(fc1) && !fpg_mode_set(cmd.data)) begin
                    next_settle_val = 16'(READ_WAIT_CYCLES); // see R18
                  end else if (fc1[FPG_BIT_SOFTWARE_WRITE_PERMIT]
                      && !cmd.data[FPG_BIT_SOFTWARE_WRITE_PERMIT]) begin
                    next_settle_val = 16'(FPG_SWE_WAIT_CYCLES); // see R17
                  end
                end
                // single byte write, never wider
                next_bus = '{addr: cmd.addr, wdata: cmd.data,
                             we: 1'b1, re: 1'b0}; // see R19
                tmr_load = 1'b1;
                next_cmd_ready = 1'b0;
                next_state = ST_ACCESS;
              end
            end
            FPG_OP_REG_RD: begin
              next_bus = '{addr: cmd.addr, wdata: 8'h00,
                           we: 1'b0, re: 1'b1}; // see R19
              tmr_load = 1'b1;
              next_cmd_ready = 1'b0;
              next_state = ST_ACCESS;
            end
            FPG_OP_FLASH_RD: begin
              // verify reads allowed only with a verify bit set
              if ((in_flash && fpg_pe_set(fc1)) // see R14
                  || (in_flash && fc1[FPG_BIT_SOFTWARE_WRITE_PERMIT]
                      && !fc1[FPG_BIT_PROGRAM_VERIFY]
                      && !fc1[FPG_BIT_ERASE_VERIFY])) begin // see R15
                next_rsp.ok = 1'b0;
                next_rsp_valid = 1'b1;
              end else begin
                next_bus = '{addr: cmd.addr, wdata: 8'h00,
                             we: 1'b0, re: 1'b1};
                tmr_load = 1'b1;
                next_cmd_ready = 1'b0;
                next_state = ST_ACCESS;
              end
            end
            FPG_OP_FLASH_WR: begin
              // programming data latch writes; a marked unit refuses its first byte again until a map clear
              if (!in_flash || fpg_pe_set(fc1) // see R14
                  || !fc1[FPG_BIT_SOFTWARE_WRITE_PERMIT]
                  || !dev_write_permit
                  || (prog_map[unit] && cmd.addr[FPG_UNIT_LSB-1:0]
                      == '0)) begin // see R06
                next_rsp.ok = 1'b0;
                next_rsp_valid = 1'b1;
              end else begin
                next_prog_map[unit] = 1'b1; // see R06
                next_bus = '{addr: cmd.addr, wdata: cmd.data,
                             we: 1'b1, re: 1'b0};
                tmr_load = 1'b1;
                next_cmd_ready = 1'b0;
                next_state = ST_ACCESS;
              end
            end
            FPG_OP_MAP_CLEAR: begin
              next_prog_map = '0; // see R06
              next_rsp_valid = 1'b1;
            end
            default: begin
              next_rsp.ok = 1'b0;
              next_rsp_valid = 1'b1;
            end
          endcase
        end
      end
      ST_RESET: begin
        if (tmr_done) begin
          next_res_n = 1'b1; // see R09
          next_rsp_valid = 1'b1;
          next_cmd_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_ACCESS: begin
        if (tmr_done) begin
          next_bus.we = 1'b0;
          next_bus.re = 1'b0;
          if (dev_bus.re) begin
            next_rsp.data = rdata_q2;
          end
          next_rsp_valid = 1'b1;
          if (settle_val != 16'h0000) begin
            tmr_load = 1'b1;
            tmr_val = settle_val;
            next_state = ST_SETTLE; // see R17
          end else begin
            next_cmd_ready = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          next_cmd_ready = 1'b1; // see R18
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_cmd_ready = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
  end

  // register the sequencer and its pins
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      fc1 <= FPG_FC1_RESET;
      wdt_armed <= 1'b0;
      prog_map <= '0;
      settle_val <= 16'h0000;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp <= '{ok: 1'b0, data: 8'h00};
      dev_res_n <= 1'b1;
      dev_write_permit <= 1'b0;
      dev_mode_select <= 3'h0;
      dev_bus <= '{addr: 20'h00000, wdata: 8'h00, we: 1'b0, re: 1'b0};
    end else begin
      state <= next_state;
      fc1 <= next_fc1;
      wdt_armed <= next_wdt_armed;
      prog_map <= next_prog_map;
      settle_val <= next_settle_val;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp <= next_rsp;
      dev_res_n <= next_res_n;
      dev_write_permit <= next_permit;
      dev_mode_select <= next_mode;
      dev_bus <= next_bus;
    end
  end

  // ------------
  // interrupt and bus release gating
  // ------------
  logic next_nmi;
  logic next_bus_req;

  // held off while the permit pin is high or the device is in reset
  always_comb begin
    next_nmi = user_nmi & !dev_write_permit & !next_permit
      & dev_res_n; // see R05
    next_bus_req = user_bus_req & !dev_write_permit & !next_permit
      & dev_res_n; // see R05
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dev_nmi <= 1'b0;
      dev_bus_req <= 1'b0;
    end else begin
      dev_nmi <= next_nmi;
      dev_bus_req <= next_bus_req;
    end
  end

endmodule : fpg_host

// File: verification/fpg_host_sva.sv
/*
 * fpg_host_sva: pin-level assertions on the flash program guard host.
 * Assumes it is bound to fpg_host and sees only mclk-domain ports.
 */
`timescale 1ns/1ns
module fpg_host_sva
  import fpg_pkg::*;
#(
  parameter int READ_WAIT_CYCLES = FPG_READ_WAIT_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic dev_res_n,
  input wire logic dev_write_permit,
  input wire logic [2:0] dev_mode_select,
  input wire logic dev_nmi,
  input wire logic dev_bus_req,
  input wire fpg_bus_t dev_bus
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic prev_we;
  logic armed;
  logic [7:0] shadow;
  logic [15:0] low_cnt;
  int quiet;
  logic wr_fc1;
  logic fl_rd;
  // first cycle of a write to register one, and any flash read
  assign wr_fc1 = dev_bus.we && !prev_we &&
    dev_bus.addr == FPG_ADDR_FLASH_CONTROL_ONE;
  assign fl_rd = dev_bus.re && dev_bus.addr <= FPG_FLASH_LAST;
  // ------------
  // shadow of the device state as seen on the pins
  // ------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_we <= 1'b0;
      armed <= 1'b0;
      shadow <= 8'h00;
      low_cnt <= 16'h0000;
      quiet <= 0;
    end else begin
      prev_we <= dev_bus.we;
      low_cnt <= dev_res_n ? 16'h0000 : low_cnt + 16'h0001;
      if (!dev_res_n) begin
        armed <= 1'b0;
        shadow <= 8'h00;
      end else begin
        if (dev_bus.we && dev_bus.addr == FPG_ADDR_WATCHDOG) begin
          armed <= 1'b1;
        end
        if (wr_fc1) begin
          shadow <= dev_write_permit ? dev_bus.wdata : 8'h00;
        end
      end
      if (wr_fc1 && shadow[3:0] != 4'h0 && dev_bus.wdata[3:0] == 4'h0) begin
        quiet <= READ_WAIT_CYCLES;
      end else if (wr_fc1 && shadow[6] && !dev_bus.wdata[6]) begin
        quiet <= FPG_SWE_WAIT_CYCLES;
      end else if (quiet > 0) begin
        quiet <= quiet - 1;
      end
    end
  end
  AST_NMI_GATED: assert property (
    dev_write_permit |-> !dev_nmi) else $error("nmi passed under permit");
  AST_BUSREQ_GATED: assert property (
    dev_write_permit |-> !dev_bus_req ##1 !dev_bus_req)
    else $error("bus request passed under permit");
  AST_RESET_WIDTH: assert property (
    $rose(dev_res_n) |-> low_cnt >= FPG_RESET_CYCLES)
    else $error("device reset pulse too short");
  AST_MODE_HELD: assert property (
    !$past(dev_res_n) |-> $stable(dev_mode_select) && $stable(dev_write_permit))
    else $error("mode pins moved during device reset");
  AST_ARM_FIRST: assert property (
    $rose(dev_write_permit) |-> armed) else $error("permit before watchdog");
  AST_DROP_CLEAN: assert property (
    $fell(dev_write_permit) && dev_res_n |-> shadow[6:0] == 7'h00)
    else $error("permit dropped with control bits set");
  AST_NO_PE_READ: assert property (
    fl_rd |-> shadow[1:0] == 2'b00) else $error("flash read during p/e");
  AST_VERIFY_ONLY: assert property (
    fl_rd |-> !shadow[6] || shadow[3:2] != 2'b00)
    else $error("plain flash read with write permit bit set");
  AST_READ_SETTLED: assert property (
    fl_rd |-> quiet == 0) else $error("flash read before settle time");
endmodule : fpg_host_sva

bind fpg_host fpg_host_sva #(.READ_WAIT_CYCLES(READ_WAIT_CYCLES)) u_sva (
  .mclk(mclk),
  .rst_n(rst_n),
  .dev_res_n(dev_res_n),
  .dev_write_permit(dev_write_permit),
  .dev_mode_select(dev_mode_select),
  .dev_nmi(dev_nmi),
  .dev_bus_req(dev_bus_req),
  .dev_bus(dev_bus)
);

// File: verification/fpg_dev_model.sv
/*
 * fpg_dev_model: behavioural flash microcontroller seen by the host.
 * Assumes register path and pins driven from mclk logic; 256-byte
 * flash image, erased to ff.
 */
`timescale 1ns/1ns
module fpg_dev_model
  import fpg_pkg::*;
(
  input wire logic mclk,
  input wire logic dev_res_n,
  input wire logic dev_write_permit,
  input wire logic [2:0] dev_mode_select,
  input wire logic dev_nmi,
  input wire fpg_bus_t dev_bus,
  output logic [7:0] dev_rdata
);
  logic [7:0] fc1 = 8'h00;
  logic [7:0] overlay = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] nmi_count = 8'h00;
  logic [7:0] mem [0:255];
  logic err = 1'b0;
  logic boot_run = 1'b0;
  logic nmi_q = 1'b0;
  logic pe;
  logic blocked;
  // erased flash image
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'hff;
    end
  end
  assign pe = fc1[FPG_BIT_PROGRAM] | fc1[FPG_BIT_ERASE];
  assign blocked = pe | err | boot_run;
  // ------------
  // register one, error protection, nmi intake and flash array
  // ------------
  always @(posedge mclk) begin
    nmi_q <= dev_nmi;
    last <= dev_rdata;
    if (!dev_res_n) begin
      fc1 <= 8'h00;
      err <= 1'b0;
      boot_run <= dev_write_permit && dev_mode_select != 3'h0;
    end else begin
      if (dev_nmi && !nmi_q && !blocked) begin
        nmi_count <= nmi_count + 8'h01;
      end
      if (dev_bus.we || dev_bus.re) begin
        boot_run <= 1'b0;
      end
      if (dev_bus.re && dev_bus.addr <= FPG_FLASH_LAST && pe) begin
        err <= 1'b1;
      end
      if (dev_bus.we && dev_bus.addr == FPG_ADDR_FLASH_CONTROL_ONE) begin
        fc1 <= dev_write_permit ? dev_bus.wdata : 8'h00;
      end else if (!dev_write_permit || !fc1[6] || err) begin
        fc1[1:0] <= 2'b00;
      end
      if (dev_bus.we && dev_bus.addr == FPG_ADDR_RAM_OVERLAY_CONTROL) begin
        overlay <= dev_bus.wdata;
      end
      if (dev_bus.we && dev_bus.addr <= FPG_FLASH_LAST && fc1[6]) begin
        mem[dev_bus.addr[7:0]] <= dev_bus.wdata;
      end
    end
  end
  // read mux; released bus shows a pattern that flips each cycle
  always_comb begin
    if (!dev_bus.re) begin
      dev_rdata = ~last;
    end else if (dev_bus.addr == FPG_ADDR_FLASH_CONTROL_ONE) begin
      dev_rdata = fc1;
    end else if (dev_bus.addr == FPG_ADDR_RAM_OVERLAY_CONTROL) begin
      dev_rdata = overlay;
    end else if (dev_bus.addr <= FPG_FLASH_LAST) begin
      dev_rdata = pe ? ~last : mem[dev_bus.addr[7:0]];
    end else begin
      dev_rdata = 8'hff; // no identification readout
    end
  end
endmodule : fpg_dev_model

// File: verification/fpg_host_tb_top.sv
/*
 * fpg_host_tb_top: directed bench for the flash program guard host.
 * Assumes fpg_dev_model on the device pins and a short read settle.
 */
`timescale 1ns/1ns
module fpg_host_tb_top
  import fpg_pkg::*;
;
  localparam int RW = 50;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  fpg_cmd_t cmd = '0;
  logic user_nmi = 1'b0;
  logic user_bus_req = 1'b0;
  logic cmd_ready, rsp_valid, dev_res_n, dev_write_permit, dev_nmi;
  logic dev_bus_req;
  fpg_rsp_t rsp;
  logic [2:0] dev_mode_select;
  fpg_bus_t dev_bus;
  logic [7:0] dev_rdata;
  logic [7:0] rdata;
  int failures = 0;
  int comparisons = 0;
  int settle;
  int lows;
  // 250 MHz clock
  always #2 mclk = ~mclk;
  fpg_host #(.READ_WAIT_CYCLES(RW)) uut (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .user_nmi(user_nmi),
    .user_bus_req(user_bus_req), .dev_res_n(dev_res_n),
    .dev_write_permit(dev_write_permit), .dev_mode_select(dev_mode_select),
    .dev_nmi(dev_nmi), .dev_bus_req(dev_bus_req), .dev_bus(dev_bus),
    .dev_rdata(dev_rdata));
  fpg_dev_model u_dev (.mclk(mclk), .dev_res_n(dev_res_n),
    .dev_write_permit(dev_write_permit), .dev_mode_select(dev_mode_select),
    .dev_nmi(dev_nmi), .dev_bus(dev_bus), .dev_rdata(dev_rdata));
  // ------------
  // shared tasks
  // ------------
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic expire(input string what);
    failures++;
    $display("ERROR %s expected handshake seen timeout", what);
    end_sim();
  endtask : expire
  // one command: offer at a falling edge, wait answer, then ready again
  task automatic send(input fpg_op_t op, input logic [19:0] a,
    input logic [7:0] d, input logic ok);
    int n;
    n = 0;
    lows = 0;
    settle = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge mclk);
      if (++n > 2000) expire("cmd_ready");
    end
    cmd_valid = 1'b1;
    cmd = '{op, a, d};
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1) begin
      @(negedge mclk);
      if (dev_res_n === 1'b0) lows++;
      if (++n > 300) expire("rsp_valid");
    end
    check("rsp_ok", rsp.ok, ok);
    rdata = rsp.data;
    while (cmd_ready !== 1'b1) begin
      @(negedge mclk);
      if (++settle > 1000) expire("settle");
    end
  endtask : send
  // ------------
  // scenarios
  // ------------
  task automatic t_refuse;
    send(FPG_OP_FWE_ON, 20'h00000, 8'h00, 1'b0);
    check("permit", dev_write_permit, 1'b0);
    send(FPG_OP_REG_WR, FPG_ADDR_FLASH_CONTROL_ONE, 8'h41, 1'b0);
    send(FPG_OP_FLASH_WR, 20'h00100, 8'h5a, 1'b0);
    send(fpg_op_t'(4'hf), 20'h00000, 8'h00, 1'b0);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_program;
    send(FPG_OP_WDT_ARM, FPG_ADDR_WATCHDOG, 8'ha5, 1'b1);
    send(FPG_OP_FWE_ON, 20'h00000, 8'h00, 1'b1);
    check("permit", dev_write_permit, 1'b1);
    send(FPG_OP_REG_WR, FPG_ADDR_FLASH_CONTROL_ONE, 8'h40, 1'b1);
    send(FPG_OP_REG_RD, FPG_ADDR_FLASH_CONTROL_ONE, 8'h00, 1'b1);
    check("fc1", rdata, 8'h40);
    send(FPG_OP_FLASH_WR, 20'h00100, 8'h5a, 1'b1);
    send(FPG_OP_FLASH_WR, 20'h00100, 8'h33, 1'b0);
    send(FPG_OP_MAP_CLEAR, 20'h00000, 8'h00, 1'b1);
    send(FPG_OP_FLASH_WR, 20'h00100, 8'h5a, 1'b1);
    send(FPG_OP_REG_WR, FPG_ADDR_FLASH_CONTROL_ONE, 8'h41, 1'b1);
    send(FPG_OP_FLASH_RD, 20'h00100, 8'h00, 1'b0);
    send(FPG_OP_FWE_OFF, 20'h00000, 8'h00, 1'b0);
    send(FPG_OP_REG_WR, FPG_ADDR_FLASH_CONTROL_ONE, 8'h40, 1'b1);
    check("read_settle", settle >= RW, 1'b1);
    send(FPG_OP_REG_WR, FPG_ADDR_FLASH_CONTROL_ONE, 8'h00, 1'b1);
    check("swe_settle", settle >= FPG_SWE_WAIT_CYCLES, 1'b1);
    send(FPG_OP_FLASH_RD, 20'h00100, 8'h00, 1'b1);
    check("flash", rdata, 8'h5a);
    send(FPG_OP_FWE_OFF, 20'h00000, 8'h00, 1'b1);
    check("permit", dev_write_permit, 1'b0);
    $display("test program done");
  endtask : t_program
  task automatic t_nmi;
    user_nmi = 1'b1;
    user_bus_req = 1'b1;
    send(FPG_OP_FWE_ON, 20'h00000, 8'h00, 1'b1);
    repeat (3) @(negedge mclk);
    check("nmi", dev_nmi, 1'b0);
    check("bus_req", dev_bus_req, 1'b0);
    send(FPG_OP_FWE_OFF, 20'h00000, 8'h00, 1'b1);
    repeat (3) @(negedge mclk);
    check("nmi", dev_nmi, 1'b1);
    check("bus_req", dev_bus_req, 1'b1);
    check("nmi_seen", u_dev.nmi_count, 8'h01);
    user_nmi = 1'b0;
    user_bus_req = 1'b0;
    $display("test nmi done");
  endtask : t_nmi
  task automatic t_boot;
    send(FPG_OP_MODE_RESET, 20'h00000, 8'h0d, 1'b1);
    check("reset_low", lows >= FPG_RESET_CYCLES, 1'b1);
    check("mode", dev_mode_select, 3'h5);
    check("permit", dev_write_permit, 1'b1);
    $display("test boot done");
  endtask : t_boot
  // main sequence
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_refuse();
    t_program();
    t_nmi();
    t_boot();
    end_sim();
  end
endmodule : fpg_host_tb_top
